// File: verilog/iq_converter_data_port.sv
// I/Q converter data port: rx sample mux, tx word capture, APB settings
`timescale 1ns/10ps
`include "iq_port_defines.svh"
`default_nettype none

module iq_converter_data_port #(
  parameter int DATA_W = 10,
  parameter int PIPE_STAGES = 7
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion clock and direction pin from the far party
  input wire logic conv_clk,
  input wire logic tx_rx_sel,
  // Shared parallel bus, split into its four signals
  input wire logic [DATA_W-1:0] conv_bus_in,
  output logic [DATA_W-1:0] conv_bus_out,
  output logic conv_bus_oe,
  output logic conv_bus_pullup,
  output logic channel_phase_flag,
  // Receive converter results, one pair per rising conversion edge
  input wire logic [DATA_W-1:0] in_phase_rx,
  input wire logic [DATA_W-1:0] quadrature_rx,
  // Transmit converter codes and analog settings
  output logic [DATA_W-1:0] in_phase_tx,
  output logic [DATA_W-1:0] quadrature_tx,
  output logic full_scale_high,
  output logic [5:0] in_phase_offset,
  output logic [5:0] quadrature_offset,
  output logic [1:0] common_mode_sel
);

  localparam int DEPTH = `RX_LAT_Q_HALF;

  // Three-stage synchronisers for pin inputs
  logic [2:0] clk_sync_ff, nxt_clk_sync;
  logic [2:0] dir_sync_ff, nxt_dir_sync;
  logic [DATA_W-1:0] bus_sync_ff [3];
  logic [DATA_W-1:0] nxt_bus_sync [3];
  logic clk_st_ff, nxt_clk_st;
  logic dir_st_ff, nxt_dir_st;
  logic rise_ev, fall_ev;

  // Registers and APB answer
  logic [`CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [5:0] trim_i_ff, nxt_trim_i;
  logic [5:0] trim_q_ff, nxt_trim_q;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // Data path
  iq_port_pkg::iq_pair_s pipe_ff [DEPTH];
  iq_port_pkg::iq_pair_s nxt_pipe [DEPTH];
  iq_port_pkg::iq_pair_s pair_ff, nxt_pair;
  iq_port_pkg::iq_pair_s dac_ff, nxt_dac;
  logic [DATA_W-1:0] i_hold_ff, nxt_i_hold;
  logic [DATA_W-1:0] bus_out_ff, nxt_bus_out;
  logic oe_ff, nxt_oe;
  logic pull_ff, nxt_pull;
  logic phase_ff, nxt_phase;
  iq_port_pkg::bus_state_e state_ff, nxt_state;
  logic want_tx, powered;

  // Offset binary midscale pair, used at reset
  function automatic iq_port_pkg::iq_pair_s mid_pair();
    iq_port_pkg::iq_pair_s p;
    p.i = `CODE_MID;
    p.q = `CODE_MID;
    return p;
  endfunction : mid_pair

  // Edge counts once the second and third stages agree on a new level
  function automatic logic edge_seen(input logic s2, input logic s3,
                                     input logic st);
    return (s2 == s3) && (s2 != st);
  endfunction : edge_seen

  // Synchroniser next state; the first stage feeds only the second
  always_comb begin
    nxt_clk_sync = {clk_sync_ff[1:0], conv_clk};
    nxt_dir_sync = {dir_sync_ff[1:0], tx_rx_sel};
    nxt_bus_sync[0] = conv_bus_in;
    nxt_bus_sync[1] = bus_sync_ff[0];
    nxt_bus_sync[2] = bus_sync_ff[1];
    rise_ev = edge_seen(clk_sync_ff[1], clk_sync_ff[2], clk_st_ff)
              && clk_sync_ff[1];
    fall_ev = edge_seen(clk_sync_ff[1], clk_sync_ff[2], clk_st_ff)
              && !clk_sync_ff[1];
    nxt_clk_st = clk_st_ff;
    nxt_dir_st = dir_st_ff;
    if (clk_sync_ff[1] == clk_sync_ff[2]) begin
      nxt_clk_st = clk_sync_ff[1];
    end
    if (dir_sync_ff[1] == dir_sync_ff[2]) begin
      nxt_dir_st = dir_sync_ff[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_ff <= 3'h0;
      dir_sync_ff <= 3'h0;
      bus_sync_ff[0] <= '0;
      bus_sync_ff[1] <= '0;
      bus_sync_ff[2] <= '0;
      clk_st_ff <= 1'b0;
      dir_st_ff <= 1'b0;
    end else begin
      clk_sync_ff <= nxt_clk_sync;
      dir_sync_ff <= nxt_dir_sync;
      bus_sync_ff <= nxt_bus_sync;
      clk_st_ff <= nxt_clk_st;
      dir_st_ff <= nxt_dir_st;
    end
  end

  // APB slave: one wait state, write and read data at the ready edge
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_trim_i = trim_i_ff;
    nxt_trim_q = trim_q_ff;
    nxt_prdata = 32'h0000_0000;
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = 1'b0;
    if (nxt_pready) begin
      unique case (paddr)
        `CTRL_OFS: begin
          if (pwrite) begin
            nxt_ctrl = pwdata[`CTRL_W-1:0];
          end
          nxt_prdata[`CTRL_W-1:0] = ctrl_ff;
        end
        `TRIM_OFS: begin
          if (pwrite) begin
            nxt_trim_i = pwdata[`TRIM_I_MSB:`TRIM_I_LSB];
            nxt_trim_q = pwdata[`TRIM_Q_MSB:`TRIM_Q_LSB];
          end
          nxt_prdata[`TRIM_I_MSB:`TRIM_I_LSB] = trim_i_ff;
          nxt_prdata[`TRIM_Q_MSB:`TRIM_Q_LSB] = trim_q_ff;
        end
        `STAT_OFS: begin
          // Read-only view of bus ownership and the latest rx word
          nxt_prdata[1:0] = state_ff;
          nxt_prdata[2] = oe_ff;
          nxt_prdata[3] = pull_ff;
          nxt_prdata[4] = dir_st_ff;
          nxt_prdata[25:16] = bus_out_ff;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RST;
      trim_i_ff <= `TRIM_RST;
      trim_q_ff <= `TRIM_RST;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      trim_i_ff <= nxt_trim_i;
      trim_q_ff <= nxt_trim_q;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Direction and bus ownership, then the rx and tx data paths
  always_comb begin
    powered = ctrl_ff[`CTRL_PWR_MSB:`CTRL_PWR_LSB] == `PWR_ACTIVE;
    want_tx = ctrl_ff[`CTRL_DIR_SOFT] ? ctrl_ff[`CTRL_SOFT_TX]
                                      : dir_st_ff;
    nxt_state = state_ff;
    nxt_pipe = pipe_ff;
    nxt_pair = pair_ff;
    nxt_dac = dac_ff;
    nxt_i_hold = i_hold_ff;
    nxt_bus_out = bus_out_ff;
    nxt_phase = phase_ff;
    unique case (state_ff)
      iq_port_pkg::ST_OFF: begin
        if (powered) begin
          nxt_state = want_tx ? iq_port_pkg::ST_TX : iq_port_pkg::ST_TURN;
        end
      end
      iq_port_pkg::ST_RX: begin
        // Drivers drop in the same cycle the state turns to tx
        if (!powered) begin
          nxt_state = iq_port_pkg::ST_OFF;
        end else if (want_tx) begin
          nxt_state = iq_port_pkg::ST_TX;
        end
      end
      iq_port_pkg::ST_TX: begin
        if (!powered) begin
          nxt_state = iq_port_pkg::ST_OFF;
        end else if (!want_tx) begin
          nxt_state = iq_port_pkg::ST_TURN;
        end
      end
      iq_port_pkg::ST_TURN: begin
        // Wait for a rising edge so the far party has released first
        if (!powered) begin
          nxt_state = iq_port_pkg::ST_OFF;
        end else if (want_tx) begin
          nxt_state = iq_port_pkg::ST_TX;
        end else if (rise_ev) begin
          nxt_state = iq_port_pkg::ST_RX;
        end
      end
    endcase
    // Flag is a delayed copy of the conversion clock
    if (rise_ev) begin
      nxt_phase = 1'b1;
    end else if (fall_ev) begin
      nxt_phase = 1'b0;
    end
    // Receive pipeline steps on both edges while rx is up
    if (state_ff == iq_port_pkg::ST_RX && (rise_ev || fall_ev)) begin
      for (int k = DEPTH - 1; k > 0; k--) begin
        nxt_pipe[k] = pipe_ff[k-1];
      end
      nxt_pipe[0] = pipe_ff[0];
      if (rise_ev) begin
        nxt_pipe[0].i = in_phase_rx;
        nxt_pipe[0].q = quadrature_rx;
        nxt_bus_out = pipe_ff[`RX_LAT_I_HALF-1].i;
      end else begin
        nxt_bus_out = pipe_ff[`RX_LAT_Q_HALF-1].q;
      end
    end
    // Transmit words are taken only while the bus is ours to read
    if (state_ff == iq_port_pkg::ST_TX) begin
      if (fall_ev) begin
        nxt_i_hold = bus_sync_ff[2];
      end
      if (rise_ev) begin
        nxt_dac = pair_ff;
        nxt_pair.i = i_hold_ff;
        nxt_pair.q = bus_sync_ff[2];
      end
    end
    // Drive only in rx; bus_out keeps the last word
    nxt_oe = nxt_state == iq_port_pkg::ST_RX;
    nxt_pull = nxt_state == iq_port_pkg::ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= iq_port_pkg::ST_OFF;
      for (int k = 0; k < DEPTH; k++) begin
        pipe_ff[k] <= mid_pair();
      end
      pair_ff <= mid_pair();
      dac_ff <= mid_pair();
      i_hold_ff <= `CODE_MID;
      bus_out_ff <= `CODE_MID;
      oe_ff <= 1'b0;
      pull_ff <= 1'b1;
      phase_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pipe_ff <= nxt_pipe;
      pair_ff <= nxt_pair;
      dac_ff <= nxt_dac;
      i_hold_ff <= nxt_i_hold;
      bus_out_ff <= nxt_bus_out;
      oe_ff <= nxt_oe;
      pull_ff <= nxt_pull;
      phase_ff <= nxt_phase;
    end
  end

  // Every output comes straight from a flip-flop
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign conv_bus_out = bus_out_ff;
  assign conv_bus_oe = oe_ff;
  assign conv_bus_pullup = pull_ff;
  assign channel_phase_flag = phase_ff;
  assign in_phase_tx = dac_ff.i;
  assign quadrature_tx = dac_ff.q;
  assign full_scale_high = ctrl_ff[`CTRL_FS_HIGH];
  assign in_phase_offset = trim_i_ff;
  assign quadrature_offset = trim_q_ff;
  assign common_mode_sel = ctrl_ff[`CTRL_CM_MSB:`CTRL_CM_LSB];

endmodule : iq_converter_data_port

`default_nettype wire

// File: verilog/iq_port_defines.svh
// Constants for the I/Q converter data port: offsets, fields, resets
`ifndef IQ_PORT_DEFINES_SVH
`define IQ_PORT_DEFINES_SVH

// Register byte offsets on the APB slave
`define CTRL_OFS 12'h000
`define TRIM_OFS 12'h004
`define STAT_OFS 12'h008
`define ADDR_W 12

// Control register fields
`define CTRL_PWR_LSB 0
`define CTRL_PWR_MSB 1
`define CTRL_DIR_SOFT 2
`define CTRL_SOFT_TX 3
`define CTRL_FS_HIGH 4
`define CTRL_CM_LSB 5
`define CTRL_CM_MSB 6
`define CTRL_W 7
`define CTRL_RST 7'h00

// Trim register fields: two 6-bit offset corrections
`define TRIM_I_LSB 0
`define TRIM_I_MSB 5
`define TRIM_Q_LSB 8
`define TRIM_Q_MSB 13
`define TRIM_RST 6'h00

// Power state codes in the control register
`define PWR_ACTIVE 2'h0
`define PWR_DOWN 2'h1
`define PWR_IDLE 2'h2
`define PWR_REF_ONLY 2'h3

// Receive latency in conversion-clock half cycles
`define RX_LAT_I_HALF 10
`define RX_LAT_Q_HALF 11

// Offset binary midscale, the code for zero
`define CODE_MID 10'h200

`endif

// File: verilog/iq_port_pkg.sv
// Types shared by the I/Q converter data port
`default_nettype none
package iq_port_pkg;
  // One I and one Q word travelling together
  typedef struct packed {
    logic [9:0] i;
    logic [9:0] q;
  } iq_pair_s;

  // Bus ownership state
  typedef enum logic [1:0] {ST_OFF, ST_RX, ST_TX, ST_TURN} bus_state_e;
endpackage : iq_port_pkg
`default_nettype wire

// File: test/iq_port_props.sv
// Pin-level checker for the converter data port
`timescale 1ns/10ps
`default_nettype none
module iq_port_props #(
  parameter int DATA_W = 10
) (
  // Bus clock, reset and APB answer
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Converter side
  input wire logic conv_clk,
  input wire logic tx_rx_sel,
  input wire logic [DATA_W-1:0] conv_bus_out,
  input wire logic conv_bus_oe,
  input wire logic conv_bus_pullup,
  input wire logic channel_phase_flag,
  input wire logic [DATA_W-1:0] in_phase_tx,
  input wire logic [DATA_W-1:0] quadrature_tx
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // One wait state, then a single-cycle answer
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  // Pull-ups on means nobody inside drives the lines
  AST_OFF_FREE: assert property (conv_bus_pullup |-> !conv_bus_oe)
    else $error("driven while pulled up");
  AST_TX_RELEASE: assert property (
    $rose(tx_rx_sel) |-> ##[1:8] !conv_bus_oe)
    else $error("bus kept in transmit");
  // Far end may start once the pin has been high a while
  AST_NO_OVERLAP: assert property (
    tx_rx_sel [*8] |-> !conv_bus_oe)
    else $error("both sides drive");
  AST_FLAG_HIGH: assert property (
    $rose(conv_clk) && conv_bus_oe |-> ##[2:7] channel_phase_flag)
    else $error("flag not high for I");
  AST_FLAG_LOW: assert property (
    $fell(conv_clk) && conv_bus_oe |-> ##[2:7] !channel_phase_flag)
    else $error("flag not low for Q");
  // Bus word moves with the flag, then stands from the first to the fifth cycle after
  AST_BUS_STANDS: assert property (
    $changed(channel_phase_flag) |-> ##2 $stable(conv_bus_out) [*4])
    else $error("bus word moved mid phase");
  AST_DAC_AT_RISE: assert property (
    !conv_bus_pullup && ($changed(in_phase_tx) || $changed(quadrature_tx))
    |-> $past(conv_clk, 3) && !$past(conv_clk, 9))
    else $error("codes moved off rising edge");
  // Main scenarios reached
  cover property ($rose(conv_bus_oe));
  cover property ($changed(in_phase_tx));
  cover property ($fell(channel_phase_flag));
endmodule : iq_port_props
bind iq_converter_data_port iq_port_props #(.DATA_W(DATA_W)) u_props (
  .pclk, .presetn, .psel, .penable, .pready, .conv_clk, .tx_rx_sel,
  .conv_bus_out, .conv_bus_oe, .conv_bus_pullup, .channel_phase_flag,
  .in_phase_tx, .quadrature_tx);
`default_nettype wire

// File: test/far_end_model.sv
// Far-end model: conversion clock, direction pin, tx words, bus level
`timescale 1ns/10ps
`default_nettype none
module far_end_model (
  // Bench request
  input wire logic pclk,
  input wire logic tx_req,
  // Device side of the bus
  input wire logic [9:0] conv_bus_out,
  input wire logic conv_bus_oe,
  input wire logic conv_bus_pullup,
  // Resolved bus and far-end pins
  output logic [9:0] conv_bus_in,
  output logic conv_clk = 1'b0,
  output logic tx_rx_sel = 1'b0
);
  int cnt_ff = 0;
  logic [9:0] x_ff = 10'h3FC;
  logic [9:0] word_ff = 10'h3FC;
  logic [9:0] last_ff = 10'h000;
  logic drv;
  // Drive only in transmit, after the device let go, never when off
  assign drv = tx_rx_sel && !conv_bus_oe && !conv_bus_pullup;
  // A released line without pull-up toggles so stale data never passes
  assign conv_bus_in = conv_bus_oe ? conv_bus_out : drv ? word_ff :
    conv_bus_pullup ? 10'h3FF : ~last_ff;
  // 17-cycle half period keeps the clock under 7.5 MHz
  always @(posedge pclk) begin
    last_ff <= conv_bus_in;
    tx_rx_sel <= tx_req;
    cnt_ff <= (cnt_ff == 16) ? 0 : cnt_ff + 1;
    if (cnt_ff == 16) begin
      conv_clk <= ~conv_clk;
    end
    if (cnt_ff == 8 && conv_clk) begin
      x_ff <= x_ff + 10'h001;
      word_ff <= x_ff + 10'h001;
    end else if (cnt_ff == 8) begin
      word_ff <= ~x_ff;
    end
  end
endmodule : far_end_model
`default_nettype wire

// File: test/iq_converter_data_port_tb_top.sv
// Bench: APB settings, receive interleave, transmit capture
`timescale 1ns/10ps
`default_nettype none
`include "iq_port_defines.svh"
module iq_converter_data_port_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic tx_req = 1'b0;
  logic [`ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] in_phase_rx = 10'h200;
  logic [9:0] quadrature_rx = 10'h200;
  logic [31:0] prdata, rdata;
  logic [9:0] conv_bus_in, conv_bus_out, in_phase_tx, quadrature_tx, w, p;
  logic [5:0] in_phase_offset, quadrature_offset;
  logic [1:0] common_mode_sel;
  logic pready, pslverr, rerr, conv_clk, tx_rx_sel, conv_bus_oe;
  logic conv_bus_pullup, channel_phase_flag, full_scale_high;
  logic [10:0] fb;
  logic [19:0] dac;
  int err_count = 0;
  int tests_run = 0;
  int n;
  assign fb = {channel_phase_flag, conv_bus_in};
  assign dac = {in_phase_tx, quadrature_tx};
  always #2 pclk = ~pclk;
  iq_converter_data_port uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_clk, .tx_rx_sel,
    .conv_bus_in, .conv_bus_out, .conv_bus_oe, .conv_bus_pullup,
    .channel_phase_flag, .in_phase_rx, .quadrature_rx, .in_phase_tx,
    .quadrature_tx, .full_scale_high, .in_phase_offset, .quadrature_offset,
    .common_mode_sel);
  far_end_model u_far (.pclk, .tx_req, .conv_bus_out, .conv_bus_oe,
    .conv_bus_pullup, .conv_bus_in, .conv_clk, .tx_rx_sel);
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  // Request held until pready is sampled high; idle cycle in front
  // A slave that never answers is caught by the watchdog alone
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Mid-phase keeps samples clear of the pin synchroniser delay
  task automatic mid(input logic rise);
    if (rise) @(posedge conv_clk);
    else @(negedge conv_clk);
    repeat (8) @(posedge pclk);
  endtask : mid
  task automatic end_sim;
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Whole run needs under 1000 cycles
  initial begin
    #40000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge pclk);
    chk(32'(conv_bus_pullup), 32'h1);
    chk(32'(dac), 32'({`CODE_MID, `CODE_MID}));
    presetn <= 1'b1;
    apb(1'b0, `CTRL_OFS, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, `CTRL_OFS, 32'h51);
    apb(1'b1, `TRIM_OFS, 32'h152A);
    apb(1'b0, `TRIM_OFS, 32'h0);
    chk(rdata, 32'h152A);
    chk(32'({full_scale_high, common_mode_sel, in_phase_offset,
      quadrature_offset}), 32'h6A95);
    apb(1'b0, `STAT_OFS, 32'h0);
    chk(32'(rdata[3:0]), 32'h8);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'({rerr, rdata[30:0]}), 32'h80000000);
    // Software direction overrides the pin, then the two other off states
    apb(1'b1, `CTRL_OFS, 32'h0C);
    apb(1'b0, `STAT_OFS, 32'h0);
    chk(32'(rdata[3:0]), 32'h2);
    apb(1'b1, `CTRL_OFS, 32'h0F);
    apb(1'b0, `STAT_OFS, 32'h0);
    chk(32'(rdata[3:0]), 32'h8);
    apb(1'b1, `CTRL_OFS, 32'h02);
    apb(1'b0, `STAT_OFS, 32'h0);
    chk(32'(rdata[3:0]), 32'h8);
    apb(1'b1, `CTRL_OFS, 32'h50);
    in_phase_rx <= 10'h155;
    quadrature_rx <= 10'h2AA;
    repeat (8) mid(1'b1);
    mid(1'b0);
    in_phase_rx <= 10'h3FF;
    quadrature_rx <= 10'h000;
    for (int k = 0; k < 6; k++) begin
      mid(1'b1);
      chk(32'(fb), k == 5 ? 32'h7FF : 32'h555);
      mid(1'b0);
      chk(32'(fb), k == 5 ? 32'h000 : 32'h2AA);
    end
    tx_req <= 1'b1;
    for (n = 0; n < 99 && conv_bus_oe !== 1'b0; n++) begin
      w = conv_bus_out;
      @(posedge pclk);
    end
    repeat (3) mid(1'b1);
    chk(32'(conv_bus_oe), 32'h0);
    p = in_phase_tx;
    for (int k = 0; k < 4; k++) begin
      mid(1'b1);
      p = p + 10'h001;
      chk(32'(dac), 32'({p, ~p}));
    end
    tx_req <= 1'b0;
    for (n = 0; n < 99 && conv_bus_oe !== 1'b1; n++) @(posedge pclk);
    chk(32'(conv_bus_oe), 32'h1);
    chk(32'(conv_bus_out), 32'(w));
    p = in_phase_tx;
    repeat (3) mid(1'b1);
    chk(32'(in_phase_tx), 32'(p));
    end_sim();
  end
endmodule : iq_converter_data_port_tb_top
`default_nettype wire
